// File: verilog/regulator_vbus_pkg.sv
// Purpose: Shared constants for the regulator control and bus-power detection logic
// Assumes: 8-bit special function register space with byte-wide data
// Notes: Reserved bits of the control register read as zero

package regulator_vbus_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] REGULATOR_CONTROL_ADDR = 8'hC9;
  localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned REGULATOR_DISABLE_BIT = 7;
  localparam int unsigned BUS_POWER_STATUS_BIT = 6;
  localparam int unsigned BUS_POWER_POLARITY_BIT = 5;
  localparam int unsigned REGULATOR_LOW_POWER_SELECT_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Field and synchroniser reset values
  localparam logic REGULATOR_DISABLE_RESET = 1'b0;
  localparam logic BUS_POWER_POLARITY_RESET = 1'b0;
  localparam logic REGULATOR_LOW_POWER_SELECT_RESET = 1'b0;
  localparam logic BUS_POWER_SYNC_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Polarity encoding
  typedef enum logic {
    POLARITY_LOW = 1'b0,
    POLARITY_HIGH = 1'b1
  } bus_power_polarity_t;

  // Address decode shared by the read and write paths
  function automatic logic regulator_control_hit(input logic [7:0] addr);
    regulator_control_hit = (addr == REGULATOR_CONTROL_ADDR);
  endfunction : regulator_control_hit

endpackage : regulator_vbus_pkg

// File: verilog/bus_power_if.sv
// Purpose: Carries the synchronised bus-power level and polarity match between modules
// Assumes: Both ends run on the system clock
// Notes: The detector drives level and match, the register bank drives polarity

`timescale 1ns/1ps

interface bus_power_if;
  logic level;
  logic polarity;
  logic match;

  modport detector (
    output level,
    output match,
    input polarity
  );

  modport bank (
    input level,
    input match,
    output polarity
  );
endinterface : bus_power_if

// File: verilog/bus_power_detect.sv
// Purpose: Synchronises the bus-power pin and compares it with the selected polarity
// Assumes: The pin is asynchronous to the system clock
// Notes: Two flip-flops of latency before the level is usable

`timescale 1ns/1ps

module bus_power_detect
  import regulator_vbus_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Cable pin
  input wire logic bus_power_pin_in,
  // Toward the register bank
  bus_power_if.detector bp
);

  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchroniser; the first stage feeds only the second
  always_comb begin
    nxt_meta = bus_power_pin_in;
    nxt_sync = meta_ff;
    if (srst_in) begin
      nxt_meta = BUS_POWER_SYNC_RESET;
      nxt_sync = BUS_POWER_SYNC_RESET;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Level match against the chosen polarity, no pending state kept
  assign bp.level = sync_ff;
  assign bp.match = (sync_ff == bp.polarity);

endmodule : bus_power_detect

// File: verilog/regulator_vbus_control.sv
// Purpose: Regulator control register, bus-power status, interrupt and reset requests
// Assumes: Core drives address, strobes and write data synchronously to sys_clk_in
// Notes: Read data is registered and valid one cycle after the read strobe

`timescale 1ns/1ps

module regulator_vbus_control
  import regulator_vbus_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Special function register access
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // Cable and system controls
  input wire logic bus_power_pin_in,
  input wire logic bus_power_irq_enable_in,
  input wire logic usb_reset_source_in,
  // Regulator and system requests
  output logic regulator_disable_out,
  output logic regulator_low_power_out,
  output logic bus_power_irq_out,
  output logic bus_power_reset_req_out
);

  bus_power_if bp ();

  ////////////////////////////////////////////////////////////////////////////////
  // Detector instance
  bus_power_detect u_detect (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .bus_power_pin_in(bus_power_pin_in),
    .bp(bp.detector)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control fields
  logic regulator_disable_ff;
  logic bus_power_polarity_ff;
  logic regulator_low_power_select_ff;
  logic nxt_regulator_disable;
  logic nxt_bus_power_polarity;
  logic nxt_regulator_low_power_select;
  logic wr_hit;

  assign wr_hit = sfr_wr_in && regulator_control_hit(sfr_addr_in);

  always_comb begin
    nxt_regulator_disable = regulator_disable_ff;
    nxt_bus_power_polarity = bus_power_polarity_ff;
    nxt_regulator_low_power_select = regulator_low_power_select_ff;
    if (srst_in) begin
      nxt_regulator_disable = REGULATOR_DISABLE_RESET;
      nxt_bus_power_polarity = BUS_POWER_POLARITY_RESET;
      nxt_regulator_low_power_select = REGULATOR_LOW_POWER_SELECT_RESET;
    end else if (wr_hit) begin
      // Status and reserved bits ignore writes
      nxt_regulator_disable = sfr_wdata_in[REGULATOR_DISABLE_BIT];
      nxt_bus_power_polarity = sfr_wdata_in[BUS_POWER_POLARITY_BIT];
      nxt_regulator_low_power_select = sfr_wdata_in[REGULATOR_LOW_POWER_SELECT_BIT];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    regulator_disable_ff <= nxt_regulator_disable;
    bus_power_polarity_ff <= nxt_bus_power_polarity;
    regulator_low_power_select_ff <= nxt_regulator_low_power_select;
  end

  assign bp.polarity = bus_power_polarity_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (!srst_in && sfr_rd_in && regulator_control_hit(sfr_addr_in)) begin
      nxt_rdata[REGULATOR_DISABLE_BIT] = regulator_disable_ff;
      nxt_rdata[BUS_POWER_STATUS_BIT] = bp.level;
      nxt_rdata[BUS_POWER_POLARITY_BIT] = bus_power_polarity_ff;
      nxt_rdata[REGULATOR_LOW_POWER_SELECT_BIT] = regulator_low_power_select_ff;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    rdata_ff <= nxt_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Requests; registered so outputs come from flops, costing one cycle
  logic irq_ff;
  logic reset_req_ff;
  logic disable_out_ff;
  logic low_power_out_ff;
  logic nxt_irq;
  logic nxt_reset_req;
  logic nxt_disable_out;
  logic nxt_low_power_out;

  always_comb begin
    nxt_irq = bus_power_irq_enable_in && bp.match;
    nxt_reset_req = usb_reset_source_in && bp.match;
    nxt_disable_out = regulator_disable_ff;
    nxt_low_power_out = regulator_low_power_select_ff;
    if (srst_in) begin
      nxt_irq = 1'b0;
      nxt_reset_req = 1'b0;
      nxt_disable_out = REGULATOR_DISABLE_RESET;
      nxt_low_power_out = REGULATOR_LOW_POWER_SELECT_RESET;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    irq_ff <= nxt_irq;
    reset_req_ff <= nxt_reset_req;
    disable_out_ff <= nxt_disable_out;
    low_power_out_ff <= nxt_low_power_out;
  end

  assign sfr_rdata_out = rdata_ff;
  assign regulator_disable_out = disable_out_ff;
  assign regulator_low_power_out = low_power_out_ff;
  assign bus_power_irq_out = irq_ff;
  assign bus_power_reset_req_out = reset_req_ff;

endmodule : regulator_vbus_control

// File: testbench/vbus_cable_model.sv
// Purpose: Cable model driving the bus-power pin
// Assumes: Attach requests come from the bench
// Notes: The level lands off the clock edge
`timescale 1ns/1ps
module vbus_cable_model (
  // Bench request
  input wire logic attach_in,
  // Pin toward the device
  output logic bus_power_out
);
  // Delay keeps the pin asynchronous to the system clock
  initial bus_power_out = 1'b0;
  always @(attach_in) bus_power_out <= #3 attach_in;
endmodule : vbus_cable_model

// File: testbench/regulator_vbus_asserts.sv
// Purpose: Port checks of control fields and bus-power requests
// Assumes: One clock, synchronous active-high reset
// Notes: Steady windows allow for the two-flop synchroniser
`timescale 1ns/1ps
module regulator_vbus_asserts
  import regulator_vbus_pkg::*;
(
  input wire logic sys_clk_in, srst_in, sfr_wr_in, sfr_rd_in,
  input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out,
  input wire logic bus_power_pin_in, bus_power_irq_enable_in, usb_reset_source_in,
  input wire logic regulator_disable_out, regulator_low_power_out,
  input wire logic bus_power_irq_out, bus_power_reset_req_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  wire wr_hit = sfr_wr_in && sfr_addr_in == REGULATOR_CONTROL_ADDR;
  wire rd_hit = sfr_rd_in && sfr_addr_in == REGULATOR_CONTROL_ADDR;
  sequence pin_calm;
    $stable(bus_power_pin_in)[*3];
  endsequence
  sequence pol_write;
    pin_calm ##0 (wr_hit && bus_power_irq_enable_in)
      ##1 ($stable(bus_power_pin_in) && bus_power_irq_enable_in)[*2];
  endsequence
  // Six quiet cycles cover the synchroniser flush after a pin change
  sequence quiet;
    ($stable(bus_power_pin_in) && !sfr_wr_in && $stable(bus_power_irq_enable_in))[*6];
  endsequence
  chk_disable_write: assert property (
    wr_hit |-> ##2 regulator_disable_out == $past(sfr_wdata_in[7], 2)) else $error("Bad disable");
  chk_lowpow_write: assert property (
    wr_hit |-> ##2 regulator_low_power_out == $past(sfr_wdata_in[4], 2)) else $error("Bad mode");
  chk_status_read: assert property (
    pin_calm ##0 rd_hit |=> sfr_rdata_out[6] == $past(bus_power_pin_in)) else $error("Bad status");
  chk_read_fields: assert property (rd_hit |=> sfr_rdata_out[3:0] == 4'h0 &&
    sfr_rdata_out[7] == regulator_disable_out && sfr_rdata_out[4] == regulator_low_power_out)
    else $error("Bad read");
  chk_pol_select: assert property (
    pol_write |-> bus_power_irq_out == (bus_power_pin_in == $past(sfr_wdata_in[5], 2)))
    else $error("Bad polarity");
  chk_irq_gate: assert property (
    !$past(bus_power_irq_enable_in) |-> !bus_power_irq_out) else $error("Irq not gated");
  chk_irq_rst_pair: assert property (
    $past(bus_power_irq_enable_in) && $past(usb_reset_source_in)
      |-> bus_power_irq_out == bus_power_reset_req_out) else $error("Requests differ");
  chk_irq_steady: assert property (
    quiet |-> $stable(bus_power_irq_out)) else $error("Irq moved");
endmodule : regulator_vbus_asserts
bind regulator_vbus_control regulator_vbus_asserts i_chk (.sys_clk_in, .srst_in, .sfr_wr_in,
  .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in, .sfr_rdata_out, .bus_power_pin_in,
  .bus_power_irq_enable_in, .usb_reset_source_in, .regulator_disable_out,
  .regulator_low_power_out, .bus_power_irq_out, .bus_power_reset_req_out);

// File: testbench/regulator_vbus_control_tb_top.sv
// Purpose: Self-checking bench for the regulator control block
// Assumes: Reset held 20 cycles
// Notes: Reads are checked one cycle after the strobe
`timescale 1ns/1ps
module regulator_vbus_control_tb_top;
  import regulator_vbus_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic plug = 1'b0;
  logic bus_power_irq_enable_in = 1'b0;
  logic usb_reset_source_in = 1'b0;
  logic bus_power_pin_in, regulator_disable_out, regulator_low_power_out;
  logic bus_power_irq_out, bus_power_reset_req_out;
  logic [7:0] sfr_rdata_out;
  int failures = 0;
  int num_checks = 0;
  regulator_vbus_control i_dut (.sys_clk_in, .srst_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
    .sfr_wdata_in, .sfr_rdata_out, .bus_power_pin_in, .bus_power_irq_enable_in,
    .usb_reset_source_in, .regulator_disable_out, .regulator_low_power_out,
    .bus_power_irq_out, .bus_power_reset_req_out);
  vbus_cable_model i_cable (.attach_in(plug), .bus_power_out(bus_power_pin_in));
  initial forever #5 sys_clk_in = ~sys_clk_in;
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cyc
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_wr_in <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_rd_in <= 1'b0;
    #1;
    check(sfr_rdata_out, exp);
  endtask : rd_reg
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    rd_reg(8'hC9, 8'h00);
    wr_reg(8'hC9, 8'hFF);
    rd_reg(8'hC9, 8'hB0);
    check({6'h00, regulator_disable_out, regulator_low_power_out}, 8'h03);
    wr_reg(8'hC8, 8'h00);
    rd_reg(8'hC8, 8'h00);
    rd_reg(8'hC9, 8'hB0);
    wr_reg(8'hC9, 8'h80);
    rd_reg(8'hC9, 8'h80);
    check({6'h00, regulator_disable_out, regulator_low_power_out}, 8'h02);
    $display("Register test done");
    @(posedge sys_clk_in);
    bus_power_irq_enable_in <= 1'b1;
    usb_reset_source_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      plug <= i[0];
      cyc(2);
      wr_reg(8'hC9, {2'b00, i[1], 5'h00});
      cyc(6);
      check({6'h00, bus_power_irq_out, bus_power_reset_req_out}, {6'h00, {2{i[0] == i[1]}}});
      rd_reg(8'hC9, {1'b0, i[0], i[1], 5'h00});
    end
    check({6'h00, regulator_disable_out, regulator_low_power_out}, 8'h00);
    $display("Polarity test done");
    @(posedge sys_clk_in);
    bus_power_irq_enable_in <= 1'b0;
    cyc(3);
    check({6'h00, bus_power_irq_out, bus_power_reset_req_out}, 8'h01);
    @(posedge sys_clk_in);
    usb_reset_source_in <= 1'b0;
    bus_power_irq_enable_in <= 1'b1;
    cyc(3);
    check({6'h00, bus_power_irq_out, bus_power_reset_req_out}, 8'h02);
    $display("Gating test done");
    stop_test();
  end
  // Whole run takes about 100 cycles; twenty times that means a hang
  initial begin
    repeat (2000) @(posedge sys_clk_in);
    failures++;
    stop_test();
  end
endmodule : regulator_vbus_control_tb_top
